// file: design/err_flag_pkg.sv
package err_flag_pkg;
  // Clock rate and period
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  // Clock switch waits, as printed, in ns
  localparam int SWITCH_200_US_NS = 200_000;
  localparam int SWITCH_100_US_NS = 100_000;
  localparam int SWITCH_50_US_NS = 50_000;
  // Least times round up to whole cycles
  localparam int SWITCH_200_CYC = (SWITCH_200_US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SWITCH_100_CYC = (SWITCH_100_US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SWITCH_50_CYC = (SWITCH_50_US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_W = 14;

  // Register location in the command byte
  localparam logic [3:0] ERR_CTRL_OFFSET = 4'h9;
  localparam logic [1:0] CMD_LOW_BITS = 2'h0;
  localparam logic [7:0] ERR_CTRL_RESET = 8'h00;
  localparam int FRAME_BITS = 16;
  localparam int BITCNT_W = 5;

  // Field positions of the control byte
  localparam int MUTE_SEL_BIT = 0;
  localparam int PARITY_MODE_BIT = 1;
  localparam int SWITCH_WAIT_LSB = 2;
  localparam int FORCE_BIT = 4;
  localparam int RATE_MASK_BIT = 5;
  localparam int RELEASE_WAIT_LSB = 6;

  localparam logic [1:0] SWITCH_IMMEDIATE = 2'h3;

  // Block-start counts before the error is released
  localparam int REL_W = 9;
  localparam logic [REL_W-1:0] RELEASE_CNT_0 = 9'h180;
  localparam logic [REL_W-1:0] RELEASE_CNT_1 = 9'h018;
  localparam logic [REL_W-1:0] RELEASE_CNT_2 = 9'h00C;
  localparam logic [REL_W-1:0] RELEASE_CNT_3 = 9'h003;

  // Consecutive parity errors still flagged
  localparam logic [3:0] PARITY_RUN_MAX = 4'h8;
  localparam logic [3:0] PARITY_RUN_SAT = 4'hF;
endpackage

// file: design/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk, // Core clock
  input wire logic reset_n, // Sync reset, active low
  input wire logic ce, // Clock enable
  input wire logic [W-1:0] async_in, // Pin levels
  output logic [W-1:0] sync_out // Synchronised levels
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// file: design/error_flag_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Unlock: switch clock after coded oscillator wait
// - Code 11 switches clock at unlock
// - Force clear: pin shows unlock, release wait and parity errors
// - Force set: pin held high
// - Mask bit stops rate changes raising error
// - Mode bit governs parity flagging on PCM
// - Mode zero: parity flag only non-PCM
// - Release wait sets error clear after lock
// - Select bit mutes audio on non-PCM error
// - Forcing error leaves audio outputs alone
// - Oscillator stopped: use channel-status rate only
module error_flag_ctrl #(
  parameter int SWITCH_200_CYC = err_flag_pkg::SWITCH_200_CYC
) (
  input wire logic clk, // Core clock
  input wire logic reset_n, // Sync reset, active low
  input wire logic ce, // Clock enable
  input wire logic ser_clk_pin, // Control bus clock pin
  input wire logic ser_data_pin, // Control bus data pin
  input wire logic ser_enable_pin, // Control bus enable pin
  input wire logic [1:0] chip_addr_pin, // Chip address straps
  input wire logic pll_locked, // PLL lock level
  input wire logic osc_running, // Oscillator amp running
  input wire logic fs_change_calc, // Rate change from own calc
  input wire logic fs_change_cs, // Rate change from channel status
  input wire logic block_start, // Block preamble seen, pulse
  input wire logic subframe_strobe, // Subframe end, pulse
  input wire logic parity_error, // Parity error this subframe
  input wire logic nonpcm_detected, // Non-PCM stream level
  output logic error_flag_pin, // Error flag, high is error
  output logic clock_from_osc, // Output clock on oscillator
  output logic audio_mute // Audio data muted
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [4:0] pins_s;
  logic sclk_s, sdat_s, sen_s;
  logic [1:0] addr_s;
  pin_sync #(.W(5)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .async_in({chip_addr_pin, ser_enable_pin, ser_data_pin, ser_clk_pin}),
    .sync_out(pins_s)
  );
  assign sclk_s = pins_s[0];
  assign sdat_s = pins_s[1];
  assign sen_s = pins_s[2];
  assign addr_s = pins_s[4:3];

  // ----------------------------------------
  // Serial command receiver
  // ----------------------------------------
  logic sclk_prev_q, sen_prev_q;
  logic [15:0] shift_q;
  logic [err_flag_pkg::BITCNT_W-1:0] bitcnt_q;
  logic [7:0] ctrl_q;
  logic frame_hit;

  // Byte one: DI7..DI4 offset, DI3..DI2 zero, DI1..DI0 chip address
  assign frame_hit = sen_prev_q && !sen_s
    && (bitcnt_q == err_flag_pkg::BITCNT_W'(err_flag_pkg::FRAME_BITS))
    && (shift_q[7:4] == err_flag_pkg::ERR_CTRL_OFFSET)
    && (shift_q[3:2] == err_flag_pkg::CMD_LOW_BITS)
    && (shift_q[1:0] == addr_s);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sclk_prev_q <= 1'b0;
      sen_prev_q <= 1'b0;
      shift_q <= 16'h0000;
      bitcnt_q <= '0;
    end else if (ce) begin
      sclk_prev_q <= sclk_s;
      sen_prev_q <= sen_s;
      if (!sen_s) begin
        bitcnt_q <= '0;
      end else if (sclk_s && !sclk_prev_q) begin
        // First bit in lands at DI0 after sixteen shifts
        shift_q <= {sdat_s, shift_q[15:1]};
        if (bitcnt_q != err_flag_pkg::BITCNT_W'(err_flag_pkg::FRAME_BITS))
          bitcnt_q <= bitcnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_q <= err_flag_pkg::ERR_CTRL_RESET;
    end else if (ce && frame_hit) begin
      ctrl_q <= shift_q[15:8];
    end
  end

  logic mute_sel, parity_mode, force_err, rate_mask;
  logic [1:0] sw_code, rel_code;
  assign mute_sel = ctrl_q[err_flag_pkg::MUTE_SEL_BIT];
  assign parity_mode = ctrl_q[err_flag_pkg::PARITY_MODE_BIT];
  assign sw_code = ctrl_q[err_flag_pkg::SWITCH_WAIT_LSB +: 2];
  assign force_err = ctrl_q[err_flag_pkg::FORCE_BIT];
  assign rate_mask = ctrl_q[err_flag_pkg::RATE_MASK_BIT];
  assign rel_code = ctrl_q[err_flag_pkg::RELEASE_WAIT_LSB +: 2];

  // ----------------------------------------
  // Clock switch after unlock
  // ----------------------------------------
  logic [err_flag_pkg::WAIT_W-1:0] wait_cnt_q, wait_limit;
  always_comb begin
    case (sw_code)
      2'h0: wait_limit = err_flag_pkg::WAIT_W'(SWITCH_200_CYC);
      2'h1: wait_limit = err_flag_pkg::WAIT_W'(err_flag_pkg::SWITCH_100_CYC);
      2'h2: wait_limit = err_flag_pkg::WAIT_W'(err_flag_pkg::SWITCH_50_CYC);
      default: wait_limit = err_flag_pkg::WAIT_W'(1);
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      clock_from_osc <= 1'b0;
      wait_cnt_q <= '0;
    end else if (ce) begin
      if (pll_locked) begin
        clock_from_osc <= 1'b0;
        wait_cnt_q <= '0;
      end else if (!clock_from_osc) begin
        if (sw_code == err_flag_pkg::SWITCH_IMMEDIATE) begin
          clock_from_osc <= 1'b1;
        end else if (osc_running) begin
          wait_cnt_q <= wait_cnt_q + 1'b1;
          if (wait_cnt_q + 1'b1 >= wait_limit)
            clock_from_osc <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Rate change and error release
  // ----------------------------------------
  logic fs_chg;
  assign fs_chg = !rate_mask && (fs_change_cs || (fs_change_calc && osc_running));

  logic [err_flag_pkg::REL_W-1:0] rel_cnt_q, rel_target;
  logic released_q;
  always_comb begin
    case (rel_code)
      2'h0: rel_target = err_flag_pkg::RELEASE_CNT_0;
      2'h1: rel_target = err_flag_pkg::RELEASE_CNT_1;
      2'h2: rel_target = err_flag_pkg::RELEASE_CNT_2;
      default: rel_target = err_flag_pkg::RELEASE_CNT_3;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rel_cnt_q <= '0;
      released_q <= 1'b0;
    end else if (ce) begin
      if (!pll_locked || fs_chg) begin
        rel_cnt_q <= '0;
        released_q <= 1'b0;
      end else if (!released_q && block_start) begin
        rel_cnt_q <= rel_cnt_q + 1'b1;
        if (rel_cnt_q + 1'b1 >= rel_target)
          released_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Repeated parity errors
  // ----------------------------------------
  logic [3:0] run_q;
  logic parity_flag_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      run_q <= 4'h0;
      parity_flag_q <= 1'b0;
    end else if (ce && subframe_strobe) begin
      if (!parity_error)
        run_q <= 4'h0;
      else if (run_q != err_flag_pkg::PARITY_RUN_SAT)
        run_q <= run_q + 1'b1;
      parity_flag_q <= parity_error && (run_q < err_flag_pkg::PARITY_RUN_MAX)
        && (parity_mode || nonpcm_detected);
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Force only reaches the flag pin, never the audio path
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      error_flag_pin <= 1'b1;
      audio_mute <= 1'b1;
    end else if (ce) begin
      error_flag_pin <= force_err || !pll_locked || !released_q || parity_flag_q;
      audio_mute <= !released_q || (mute_sel && nonpcm_detected && parity_flag_q);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_defaults;
    @(posedge clk) !reset_n |=> ctrl_q == err_flag_pkg::ERR_CTRL_RESET;
  endproperty
  a_defaults: assert property (p_defaults) else $error("control not zero after reset");

  property p_force;
    @(posedge clk) disable iff (!reset_n) ce && force_err |=> error_flag_pin;
  endproperty
  a_force: assert property (p_force) else $error("forced error not high");

  property p_unlock_err;
    @(posedge clk) disable iff (!reset_n) ce && !pll_locked |=> error_flag_pin;
  endproperty
  a_unlock_err: assert property (p_unlock_err) else $error("unlock not flagged");

  property p_immediate;
    @(posedge clk) disable iff (!reset_n)
      ce && !pll_locked && sw_code == err_flag_pkg::SWITCH_IMMEDIATE |=> clock_from_osc;
  endproperty
  a_immediate: assert property (p_immediate) else $error("immediate switch missed");

  property p_switch_time;
    @(posedge clk) disable iff (!reset_n)
      $rose(clock_from_osc) |-> $past(sw_code) == err_flag_pkg::SWITCH_IMMEDIATE
      || $past(wait_cnt_q) + 1'b1 == $past(wait_limit);
  endproperty
  a_switch_time: assert property (p_switch_time) else $error("clock switched at wrong count");

  property p_release_mute;
    @(posedge clk) disable iff (!reset_n) ce && !released_q |=> audio_mute && error_flag_pin;
  endproperty
  a_release_mute: assert property (p_release_mute) else $error("audio before release");

  property p_force_no_mute;
    @(posedge clk) disable iff (!reset_n)
      ce && released_q && !(mute_sel && nonpcm_detected && parity_flag_q) |=> !audio_mute;
  endproperty
  a_force_no_mute: assert property (p_force_no_mute) else $error("audio muted without cause");

  property p_nonpcm_mute;
    @(posedge clk) disable iff (!reset_n)
      ce && mute_sel && nonpcm_detected && parity_flag_q |=> audio_mute;
  endproperty
  a_nonpcm_mute: assert property (p_nonpcm_mute) else $error("non-PCM error not muted");

  property p_mask;
    @(posedge clk) disable iff (!reset_n)
      ce && rate_mask && released_q && pll_locked |=> released_q;
  endproperty
  a_mask: assert property (p_mask) else $error("masked rate change hit flag");

  property p_osc_stopped;
    @(posedge clk) disable iff (!reset_n) !osc_running && !fs_change_cs |-> !fs_chg;
  endproperty
  a_osc_stopped: assert property (p_osc_stopped) else $error("own rate calc used while stopped");

  property p_parity_pcm;
    @(posedge clk) disable iff (!reset_n)
      ce && subframe_strobe && !parity_mode && !nonpcm_detected |=> !parity_flag_q;
  endproperty
  a_parity_pcm: assert property (p_parity_pcm) else $error("parity flag on PCM");

  property p_parity_run;
    @(posedge clk) disable iff (!reset_n)
      ce && subframe_strobe && run_q >= err_flag_pkg::PARITY_RUN_MAX |=> !parity_flag_q;
  endproperty
  a_parity_run: assert property (p_parity_run) else $error("parity flagged past run");

  c_write: cover property (@(posedge clk) disable iff (!reset_n) ce && frame_hit);
  c_switch: cover property (@(posedge clk) disable iff (!reset_n) $rose(clock_from_osc));
  c_release: cover property (@(posedge clk) disable iff (!reset_n) $rose(released_q));
  c_parity: cover property (@(posedge clk) disable iff (!reset_n) $rose(parity_flag_q));
endmodule
`default_nettype wire

// file: tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk, // Core clock
  output logic ser_clk, // Bus clock
  output logic ser_data, // Bus data
  output logic ser_en // Frame enable
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_en = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // Each level held 4 clk, past the pin sync
  task automatic send(input logic [15:0] w);
    ser_en = 1'b1;
    step(4);
    for (int i = 0; i < 16; i++) begin
      ser_data = w[i];
      step(4);
      ser_clk = 1'b1;
      step(4);
      ser_clk = 1'b0;
    end
    step(4);
    ser_en = 1'b0;
    // Released line never keeps the last bit
    ser_data = ~ser_data;
    step(8);
  endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int SW_CYC = 20;
  localparam logic [1:0] ADDR = 2'h1;
  logic clk, reset_n, ce, pll_locked, osc_running, fs_change_calc, fs_change_cs;
  logic block_start, subframe_strobe, parity_error, nonpcm_detected;
  logic ser_clk_pin, ser_data_pin, ser_enable_pin;
  logic error_flag_pin, clock_from_osc, audio_mute;
  int error_cnt, samples_checked;
  int rel[4] = '{384, 24, 12, 3};
  int wt[4] = '{SW_CYC, 4000, 2000, 0};
  host_model i_host_model (.clk(clk), .ser_clk(ser_clk_pin), .ser_data(ser_data_pin), .ser_en(ser_enable_pin));
  error_flag_ctrl #(.SWITCH_200_CYC(SW_CYC)) i_error_flag_ctrl (.clk(clk), .reset_n(reset_n), .ce(ce),
    .ser_clk_pin(ser_clk_pin), .ser_data_pin(ser_data_pin), .ser_enable_pin(ser_enable_pin),
    .chip_addr_pin(ADDR), .pll_locked(pll_locked), .osc_running(osc_running),
    .fs_change_calc(fs_change_calc), .fs_change_cs(fs_change_cs), .block_start(block_start),
    .subframe_strobe(subframe_strobe), .parity_error(parity_error), .nonpcm_detected(nonpcm_detected),
    .error_flag_pin(error_flag_pin), .clock_from_osc(clock_from_osc), .audio_mute(audio_mute));
  // ------------------------------
  // Helpers
  // ------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input string nm, input logic s, input logic e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] d, input logic [1:0] a);
    i_host_model.send({d, err_flag_pkg::ERR_CTRL_OFFSET, err_flag_pkg::CMD_LOW_BITS, a});
  endtask
  task automatic start(input logic [7:0] d, input bit w);
    reset_n = 1'b0;
    pll_locked = 1'b0;
    nonpcm_detected = 1'b0;
    osc_running = 1'b1;
    tick(16);
    reset_n = 1'b1;
    tick(1);
    if (w) wr(d, ADDR);
    pll_locked = 1'b1;
    tick(2);
  endtask
  task automatic blk(input int n);
    repeat (n) begin
      block_start = 1'b1;
      tick(1);
      block_start = 1'b0;
      tick(1);
    end
  endtask
  task automatic sf(input logic pe);
    parity_error = pe;
    subframe_strobe = 1'b1;
    tick(1);
    subframe_strobe = 1'b0;
    tick(2);
  endtask
  task automatic fsp(input bit own);
    if (own) fs_change_calc = 1'b1;
    else fs_change_cs = 1'b1;
    tick(1);
    fs_change_calc = 1'b0;
    fs_change_cs = 1'b0;
    tick(2);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ------------------------------
  // Stimulus
  // ------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Tests need about 9000 cycles; this allows four times that
  initial begin
    #1ms;
    error_cnt++;
    end_of_test();
  end
  initial begin
    {reset_n, ce, pll_locked, osc_running, fs_change_calc, fs_change_cs} = 6'h00;
    {ce, block_start, subframe_strobe, parity_error, nonpcm_detected} = 5'h10;
    error_cnt = 0;
    samples_checked = 0;
    // Code 0 relies on reset values, no write
    for (int c = 0; c < 4; c++) begin
      start({2'(c), 2'h0, 2'(c), 2'h0}, c != 0);
      chk("err_reset", error_flag_pin, 1'b1);
      chk("mute_reset", audio_mute, 1'b1);
      blk(rel[c] - 1);
      chk("err_short", error_flag_pin, 1'b1);
      blk(1);
      tick(1);
      chk("err_rel", error_flag_pin, 1'b0);
      chk("mute_rel", audio_mute, 1'b0);
      pll_locked = 1'b0;
      tick(2);
      chk("err_unlock", error_flag_pin, 1'b1);
      if (c == 3) begin
        chk("clk_now", clock_from_osc, 1'b1);
      end else begin
        tick(wt[c] - 8);
        chk("clk_early", clock_from_osc, 1'b0);
        tick(16);
        chk("clk_late", clock_from_osc, 1'b1);
      end
    end
    $display("test release_switch done");
    start(8'hC0, 1'b1);
    wr(8'hD0, 2'h2);
    blk(3);
    tick(1);
    chk("err_bad_addr", error_flag_pin, 1'b0);
    wr(8'hD0, ADDR);
    chk("err_force", error_flag_pin, 1'b1);
    chk("mute_force", audio_mute, 1'b0);
    wr(8'hC0, ADDR);
    chk("err_unforce", error_flag_pin, 1'b0);
    fsp(1'b0);
    chk("err_fs", error_flag_pin, 1'b1);
    blk(3);
    tick(1);
    wr(8'hE0, ADDR);
    fsp(1'b0);
    chk("err_fs_mask", error_flag_pin, 1'b0);
    wr(8'hC0, ADDR);
    osc_running = 1'b0;
    fsp(1'b1);
    chk("err_calc_off", error_flag_pin, 1'b0);
    fsp(1'b0);
    chk("err_cs_off", error_flag_pin, 1'b1);
    $display("test force_rate done");
    start(8'hC0, 1'b1);
    blk(3);
    tick(1);
    sf(1'b1);
    chk("par_pcm", error_flag_pin, 1'b0);
    nonpcm_detected = 1'b1;
    sf(1'b1);
    chk("par_npcm", error_flag_pin, 1'b1);
    chk("mute_nosel", audio_mute, 1'b0);
    wr(8'hC1, ADDR);
    sf(1'b1);
    chk("mute_sel", audio_mute, 1'b1);
    nonpcm_detected = 1'b0;
    wr(8'hC2, ADDR);
    sf(1'b0);
    repeat (8) sf(1'b1);
    chk("par_run8", error_flag_pin, 1'b1);
    sf(1'b1);
    chk("par_run9", error_flag_pin, 1'b0);
    $display("test parity done");
    end_of_test();
  end
endmodule
`default_nettype wire
